// ### rtl/aec_regs.sv
`timescale 1ns/1ps
module aec_regs
	import aec_pkg::*;
#(
	parameter int LOGIC_CYC = aec_pkg::LOGIC_TEST_CYC,
	parameter int FRONT_CYC = aec_pkg::FRONT_TEST_CYC,
	parameter int CNT_W     = 20
) (
	input  wire logic                       ref_clk,
	input  wire logic                       rst_n,
	input  wire logic [aec_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic                       reg_wr,
	input  wire logic [aec_pkg::DATA_W-1:0] reg_wdata,
	output logic      [aec_pkg::DATA_W-1:0] reg_rdata,
	input  wire logic [aec_pkg::FLAG_W-1:0] error_mask_lo,
	input  wire logic [aec_pkg::FLAG_W-1:0] error_mask_hi,
	input  wire logic [1:0]                 selftest_select_field,
	input  wire logic                       averaging_default_field,
	input  wire logic [aec_pkg::THR_W-1:0]  magnet_loss_threshold,
	input  wire logic [aec_pkg::THR_W-1:0]  field_strength,
	input  wire logic                       eeprom_uncorrectable_evt,
	input  wire logic                       eeprom_corrected_evt,
	input  wire logic                       overtemp_evt,
	input  wire logic                       turns_overflow_evt,
	input  wire logic                       internal_logic_error_evt,
	input  wire logic                       supply_loss_evt,
	input  wire logic                       transport_exit_evt,
	input  wire logic                       line_code_error_evt,
	input  wire logic                       logic_selftest_fail_evt,
	input  wire logic                       frontend_selftest_fail_evt,
	output logic                            serial_error_flag,
	output logic                            turns_clear,
	output logic                            averaging_enable,
	output logic                            low_power_select,
	output logic                            logic_selftest_run,
	output logic                            frontend_selftest_run,
	output logic                            angle_hold
);
	import aec_pkg::*;

	// ****************************************
	// register access decode
	// ****************************************
	logic [FLAG_W-1:0] err_r;
	logic [FLAG_W-1:0] error_flags_second_r;
	logic [FLAG_W-1:0] err_nxt;
	logic [FLAG_W-1:0] error_flags_second_nxt;
	logic [FLAG_W-1:0] err_set_w;
	logic [FLAG_W-1:0] error_flags_second_set_w;
	logic              avg_r;
	logic              lp_r;
	logic              loaded_r;
	logic              avg_nxt;
	logic              lp_nxt;
	logic              ctrl_wr_w;
	logic              err_clr_w;
	logic              trn_clr_w;
	logic              st_start_w;
	logic [DATA_W-1:0] rd_mux_w;
	logic [CTRL_W-1:0] ctrl_rd_w;
	logic              err_any_w;

	assign ctrl_wr_w  = reg_wr && (reg_addr == ADDR_CTRL);
	assign err_clr_w  = ctrl_wr_w && reg_wdata[BIT_ERR_CLEAR];
	assign trn_clr_w  = ctrl_wr_w && reg_wdata[BIT_TURNS_CLEAR];
	assign st_start_w = ctrl_wr_w && reg_wdata[BIT_SELFTEST];

	// command bits never hold state, so they read as zero
	assign ctrl_rd_w = CTRL_W'({avg_r, lp_r, 1'b0} << BIT_ERR_CLEAR);

	assign rd_mux_w =
		(reg_addr == ADDR_ERR)  ? DATA_W'(err_r)     :
		(reg_addr == ADDR_ERROR_FLAGS_SECOND) ? DATA_W'(error_flags_second_r)    :
		(reg_addr == ADDR_CTRL) ? DATA_W'(ctrl_rd_w) :
		'0;

	// ****************************************
	// error flag sources
	// ****************************************
	always_comb begin
		err_set_w                    = '0;
		err_set_w[BIT_EEPROM_UNCORR] = eeprom_uncorrectable_evt;
		err_set_w[BIT_EEPROM_CORR]   = eeprom_corrected_evt;
		err_set_w[BIT_OVERTEMP]      = overtemp_evt;
		err_set_w[BIT_TURNS_OVF]     = turns_overflow_evt;
		err_set_w[BIT_INTERNAL_ERR]  = internal_logic_error_evt;
		err_set_w[BIT_MAGNET_LOSS]   = field_strength < magnet_loss_threshold;
		err_set_w[BIT_SUPPLY_LOSS]   = supply_loss_evt || transport_exit_evt;
		error_flags_second_set_w                   = '0;
		error_flags_second_set_w[BIT_LINE_CODE]    = line_code_error_evt;
		error_flags_second_set_w[BIT_LOGIC_FAIL]   = logic_selftest_fail_evt;
		error_flags_second_set_w[BIT_FRONT_FAIL]   = frontend_selftest_fail_evt;
	end

	// set beats clear so an event in the clearing cycle survives
	genvar gi;
	generate
		for (gi = 0; gi < FLAG_W; gi++) begin : g_flag
			assign err_nxt[gi]  = ERR_USED[gi] &&
				(err_set_w[gi] || (err_r[gi] && !err_clr_w));
			assign error_flags_second_nxt[gi] = ERROR_FLAGS_SECOND_USED[gi] &&
				(error_flags_second_set_w[gi] || (error_flags_second_r[gi] && !err_clr_w));
		end
	endgenerate

	// mask only gates the indicator, never the stored flag
	assign err_any_w = |(err_r & ~error_mask_lo) || |(error_flags_second_r & ~error_mask_hi);

	// ****************************************
	// control bits
	// ****************************************
	// eeprom default is caught on the first clock after reset release
	assign avg_nxt = !loaded_r ? averaging_default_field :
		ctrl_wr_w ? reg_wdata[BIT_AVERAGING] : avg_r;
	assign lp_nxt  = ctrl_wr_w ? reg_wdata[BIT_LOW_POWER] : lp_r;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			err_r             <= ERR_RST;
			error_flags_second_r            <= ERROR_FLAGS_SECOND_RST;
			avg_r             <= 1'b0;
			lp_r              <= 1'b0;
			loaded_r          <= 1'b0;
			reg_rdata         <= '0;
			serial_error_flag <= 1'b0;
			turns_clear       <= 1'b0;
		end else begin
			err_r             <= err_nxt;
			error_flags_second_r            <= error_flags_second_nxt;
			avg_r             <= avg_nxt;
			lp_r              <= lp_nxt;
			loaded_r          <= 1'b1;
			reg_rdata         <= rd_mux_w;
			serial_error_flag <= err_any_w;
			turns_clear       <= trn_clr_w;
		end
	end

	assign averaging_enable = avg_r;
	assign low_power_select = lp_r;

	// ****************************************
	// self-test sequencer
	// ****************************************
	aec_state_t       state_r;
	aec_state_t       state_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic [1:0]       sel_r;
	logic [1:0]       sel_nxt;
	logic             logic_end_w;
	logic             front_end_w;

	assign logic_end_w = cnt_r == CNT_W'(LOGIC_CYC - 1);
	assign front_end_w = cnt_r == CNT_W'(FRONT_CYC - 1);
	// a start while a test runs is dropped; tests are not restartable
	assign sel_nxt = (state_r == AEC_ST_IDLE && st_start_w) ? selftest_select_field : sel_r;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			AEC_ST_IDLE: begin
				if (st_start_w && selftest_select_field[SEL_LOGIC]) begin
					state_nxt = AEC_ST_LOGIC;
				end else if (st_start_w && selftest_select_field[SEL_FRONT]) begin
					state_nxt = AEC_ST_FRONT;
				end
			end
			AEC_ST_LOGIC: begin
				if (logic_end_w) begin
					state_nxt = sel_r[SEL_FRONT] ? AEC_ST_FRONT : AEC_ST_IDLE;
				end
			end
			AEC_ST_FRONT: begin
				if (front_end_w) begin
					state_nxt = AEC_ST_IDLE;
				end
			end
			default: state_nxt = AEC_ST_IDLE;
		endcase
	end

	assign cnt_nxt = (state_nxt != state_r || state_r == AEC_ST_IDLE) ? '0 :
		CNT_W'(cnt_r + 1'b1);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_r               <= AEC_ST_IDLE;
			cnt_r                 <= '0;
			sel_r                 <= 2'h0;
			logic_selftest_run    <= 1'b0;
			frontend_selftest_run <= 1'b0;
			angle_hold            <= 1'b0;
		end else begin
			state_r               <= state_nxt;
			cnt_r                 <= cnt_nxt;
			sel_r                 <= sel_nxt;
			logic_selftest_run    <= state_nxt == AEC_ST_LOGIC;
			frontend_selftest_run <= state_nxt == AEC_ST_FRONT;
			angle_hold            <= state_nxt != AEC_ST_IDLE;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_flag_sticky: assert property (!err_clr_w |=> ($past(err_r) & ~err_r) == '0)
		else $error("error flag dropped without clear");
	a_err_ind: assert property (err_any_w |=> serial_error_flag)
		else $error("indicator missing for unmasked flag");
	a_mask_block: assert property (((err_r & ~error_mask_lo) == '0 &&
		(error_flags_second_r & ~error_mask_hi) == '0) |=> !serial_error_flag)
		else $error("masked flag drove indicator");
	a_magnet_set: assert property (field_strength < magnet_loss_threshold
		|=> err_r[BIT_MAGNET_LOSS])
		else $error("magnet loss not flagged");
	a_clear_flags: assert property (err_clr_w && err_set_w == '0 && error_flags_second_set_w == '0
		|=> err_r == '0 && error_flags_second_r == '0)
		else $error("error clear failed");
	a_cmd_read: assert property (##1 reg_addr == ADDR_CTRL |=>
		reg_rdata[BIT_SELFTEST] == 1'b0 && reg_rdata[BIT_TURNS_CLEAR] == 1'b0 &&
		reg_rdata[BIT_ERR_CLEAR] == 1'b0)
		else $error("command bit read back as one");
	a_turns_pulse: assert property (trn_clr_w |=>
		turns_clear ##1 (!turns_clear || $past(trn_clr_w)))
		else $error("turns clear pulse wrong");
	a_avg_write: assert property (ctrl_wr_w && loaded_r |=>
		averaging_enable == $past(reg_wdata[BIT_AVERAGING]))
		else $error("averaging bit not written");
	a_lp_write: assert property (ctrl_wr_w |=>
		low_power_select == $past(reg_wdata[BIT_LOW_POWER]))
		else $error("low power select not written");
	a_test_start: assert property (state_r == AEC_ST_IDLE && st_start_w &&
		selftest_select_field[SEL_LOGIC] |=> logic_selftest_run && angle_hold)
		else $error("logic self-test did not start");
	a_logic_len: assert property ($fell(logic_selftest_run) |->
		$past(cnt_r) == CNT_W'(LOGIC_CYC - 1))
		else $error("logic self-test length wrong");
	a_front_len: assert property ($fell(frontend_selftest_run) |->
		$past(cnt_r) == CNT_W'(FRONT_CYC - 1))
		else $error("front-end self-test length wrong");
	a_reserved_zero: assert property (reg_rdata[DATA_W-1:FLAG_W] == '0)
		else $error("reserved bits read nonzero");

	// ****************************************
	// flag sources and command side effects
	// ****************************************
	// each source pin checked on its own bit so a swapped wire shows up, except supply loss and transport exit, which share bit 0
	a_uncorr_set: assert property (eeprom_uncorrectable_evt |=>
		err_r[BIT_EEPROM_UNCORR])
		else $error("uncorrectable eeprom flag not set");
	a_corr_set: assert property (eeprom_corrected_evt |=>
		err_r[BIT_EEPROM_CORR])
		else $error("corrected eeprom flag not set");
	a_overtemp_set: assert property (overtemp_evt |=>
		err_r[BIT_OVERTEMP])
		else $error("temperature flag not set");
	a_turns_ovf_set: assert property (turns_overflow_evt |=>
		err_r[BIT_TURNS_OVF])
		else $error("turns overflow flag not set");
	a_logic_err_set: assert property (internal_logic_error_evt |=>
		err_r[BIT_INTERNAL_ERR])
		else $error("internal error flag not set");
	a_supply_set: assert property (supply_loss_evt || transport_exit_evt |=>
		err_r[BIT_SUPPLY_LOSS])
		else $error("supply loss flag not set");
	a_line_code_set: assert property (line_code_error_evt |=>
		error_flags_second_r[BIT_LINE_CODE])
		else $error("line code flag not set");
	a_logic_fail_set: assert property (logic_selftest_fail_evt |=>
		error_flags_second_r[BIT_LOGIC_FAIL])
		else $error("logic self-test fail flag not set");
	a_front_fail_set: assert property (frontend_selftest_fail_evt |=>
		error_flags_second_r[BIT_FRONT_FAIL])
		else $error("front-end self-test fail flag not set");
	a_turns_no_spurious: assert property (turns_clear |->
		$past(trn_clr_w))
		else $error("turns clear without command");
	a_no_spurious_start: assert property (!st_start_w && !angle_hold |=>
		!angle_hold)
		else $error("self-test started without command");
	a_front_only: assert property (state_r == AEC_ST_IDLE && st_start_w &&
		!selftest_select_field[SEL_LOGIC] && selftest_select_field[SEL_FRONT]
		|=> frontend_selftest_run && !logic_selftest_run)
		else $error("front-end only start wrong");
	a_ro_write_ignored: assert property (reg_wr && reg_addr != ADDR_CTRL &&
		err_set_w == '0 && error_flags_second_set_w == '0 |=> err_r == $past(err_r) && error_flags_second_r == $past(error_flags_second_r))
		else $error("write to read-only register changed flags");

	c_flag_clear: cover property (err_r[BIT_SUPPLY_LOSS] ##1 err_clr_w ##1 !err_r[BIT_SUPPLY_LOSS]);
	c_both_tests: cover property ($fell(logic_selftest_run) ##0 frontend_selftest_run);
	c_masked_flag: cover property (err_r[BIT_OVERTEMP] && error_mask_lo[BIT_OVERTEMP] && !serial_error_flag);
	c_set_on_clear: cover property (err_clr_w && err_set_w[BIT_OVERTEMP]);
	c_front_only: cover property ($rose(frontend_selftest_run) && !$past(logic_selftest_run));
endmodule : aec_regs

// ### rtl/aec_pkg.sv
package aec_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam int          ADDR_W        = 4;
	localparam int          DATA_W        = 13;
	localparam int          FLAG_W        = 7;
	localparam int          CTRL_W        = 8;
	localparam logic [3:0]  ADDR_ERR      = 4'h4;
	localparam logic [3:0]  ADDR_ERROR_FLAGS_SECOND     = 4'h5;
	localparam logic [3:0]  ADDR_CTRL     = 4'h8;

	// ****************************************
	// error_flags fields
	// ****************************************
	localparam int BIT_SUPPLY_LOSS   = 0;
	localparam int BIT_MAGNET_LOSS   = 1;
	localparam int BIT_INTERNAL_ERR  = 2;
	localparam int BIT_TURNS_OVF     = 3;
	localparam int BIT_OVERTEMP      = 4;
	localparam int BIT_EEPROM_CORR   = 5;
	localparam int BIT_EEPROM_UNCORR = 6;
	localparam logic [6:0] ERR_RST   = 7'h01;
	localparam logic [6:0] ERR_USED  = 7'h7f;

	// ****************************************
	// error_flags_second fields
	// ****************************************
	localparam int BIT_FRONT_FAIL    = 3;
	localparam int BIT_LOGIC_FAIL    = 4;
	localparam int BIT_LINE_CODE     = 6;
	localparam logic [6:0] ERROR_FLAGS_SECOND_RST  = 7'h00;
	localparam logic [6:0] ERROR_FLAGS_SECOND_USED = 7'h58;

	// ****************************************
	// control_commands fields
	// ****************************************
	localparam int BIT_ERR_CLEAR     = 0;
	localparam int BIT_LOW_POWER     = 1;
	localparam int BIT_AVERAGING     = 2;
	localparam int BIT_TURNS_CLEAR   = 3;
	localparam int BIT_SELFTEST      = 4;
	localparam int SEL_LOGIC         = 0;
	localparam int SEL_FRONT         = 1;
	localparam int THR_W             = 11;

	// ****************************************
	// timing
	// ****************************************
	localparam longint CLK_HZ        = 20_000_000;
	localparam longint LOGIC_TEST_MS = 10;
	localparam longint FRONT_TEST_MS = 40;
	localparam int LOGIC_TEST_CYC    = int'((LOGIC_TEST_MS * CLK_HZ) / 1000);
	localparam int FRONT_TEST_CYC    = int'((FRONT_TEST_MS * CLK_HZ) / 1000);

	typedef enum logic [1:0] {
		AEC_ST_IDLE  = 2'b00,
		AEC_ST_LOGIC = 2'b01,
		AEC_ST_FRONT = 2'b10
	} aec_state_t;
endpackage : aec_pkg

// ### dv/aec_host.sv
`timescale 1ns/1ps
// ****************************************
// host side of the register access
// ****************************************
module aec_host
	import aec_pkg::*;
(
	input  wire logic                       ref_clk,
	output logic      [aec_pkg::ADDR_W-1:0] reg_addr,
	output logic                            reg_wr,
	output logic      [aec_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic [aec_pkg::DATA_W-1:0] reg_rdata
);
	import aec_pkg::*;

	initial begin
		reg_addr = 4'h0;
		reg_wr = 1'b0;
		reg_wdata = 13'h0000;
	end

	// released data flipped so a stale word is never mistaken for a write
	task automatic wr(input logic [3:0] a, input logic [12:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wr <= 1'b1;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask : wr

	// read data lags the address by one edge
	task automatic rd(input logic [3:0] a, output logic [12:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		@(posedge ref_clk);
		@(negedge ref_clk);
		d = reg_rdata;
	endtask : rd

	task automatic clear_errors();
		wr(ADDR_CTRL, 13'h0001);
	endtask : clear_errors
endmodule : aec_host

// ### dv/tb.sv
`timescale 1ns/1ps
module tb;
	import aec_pkg::*;
	localparam int LC = 10;
	localparam int FC = 20;
	logic        ref_clk;
	logic        rst_n;
	logic [3:0]  reg_addr;
	logic        reg_wr;
	logic [12:0] reg_wdata;
	logic [12:0] reg_rdata;
	logic [10:0] evv;
	logic [10:0] thr;
	logic [6:0]  mlo;
	logic [6:0]  mhi;
	logic [1:0]  sel;
	logic        avd;
	logic [12:0] rv;
	logic        sef;
	logic        tcl;
	logic        avg;
	logic        lps;
	logic        lrun;
	logic        frun;
	logic        ahold;
	int          miscompares;
	int          compares;
	int          n_lr;
	int          n_fr;
	int          n_ah;
	int          n_tc;

	aec_regs #(.LOGIC_CYC(LC), .FRONT_CYC(FC), .CNT_W(20)) DUT (
		.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .error_mask_lo(mlo),
		.error_mask_hi(mhi), .selftest_select_field(sel), .averaging_default_field(avd),
		.magnet_loss_threshold(thr), .field_strength(evv[1] ? 11'h063 : 11'h0c8),
		.eeprom_uncorrectable_evt(evv[6]), .eeprom_corrected_evt(evv[5]),
		.overtemp_evt(evv[4]), .turns_overflow_evt(evv[3]),
		.internal_logic_error_evt(evv[2]), .supply_loss_evt(evv[0]),
		.transport_exit_evt(evv[10]), .line_code_error_evt(evv[9]),
		.logic_selftest_fail_evt(evv[8]), .frontend_selftest_fail_evt(evv[7]),
		.serial_error_flag(sef), .turns_clear(tcl), .averaging_enable(avg),
		.low_power_select(lps), .logic_selftest_run(lrun), .frontend_selftest_run(frun),
		.angle_hold(ahold));

	aec_host host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

	always #25 ref_clk = ~ref_clk;

	always @(posedge ref_clk) begin
		n_lr <= n_lr + int'(lrun === 1'b1);
		n_fr <= n_fr + int'(frun === 1'b1);
		n_ah <= n_ah + int'(ahold === 1'b1);
		n_tc <= n_tc + int'(tcl === 1'b1);
	end

	// ****************************************
	// compare and closing
	// ****************************************
	task automatic stop_test();
		if (miscompares == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test

	task automatic chk_reg(input string n, input logic [12:0] e, input logic [12:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk_reg

	task automatic chk_bit(input string n, input logic e, input logic g);
		chk_reg(n, {12'h000, e}, {12'h000, g});
	endtask : chk_bit

	task automatic chk_cnt(input string n, input int e, input int g);
		compares++;
		if (g != e) begin
			miscompares++;
			$display("MISMATCH %s expected %0d seen %0d", n, e, g);
		end
	endtask : chk_cnt

	task automatic pulse(input int k);
		@(posedge ref_clk);
		evv <= 11'h001 << k;
		@(posedge ref_clk);
		evv <= 11'h000;
	endtask : pulse

	task automatic do_reset();
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
	endtask : do_reset

	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		stop_test();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		logic [3:0]  ea;
		logic [12:0] ev;
		int          b;
		ref_clk = 1'b0;
		rst_n = 1'b0;
		evv = 11'h000;
		thr = 11'h064;
		mlo = 7'h00;
		mhi = 7'h00;
		sel = 2'b11;
		avd = 1'b1;
		miscompares = 0;
		compares = 0;
		n_lr = 0;
		n_fr = 0;
		n_ah = 0;
		n_tc = 0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		host.rd(ADDR_ERR, rv);
		chk_reg("err_rst", 13'h0001, rv);
		chk_bit("sef_rst", 1'b1, sef);
		host.rd(ADDR_ERROR_FLAGS_SECOND, rv);
		chk_reg("error_flags_second_rst", 13'h0000, rv);
		host.rd(ADDR_CTRL, rv);
		chk_reg("ctrl_rst", 13'h0004, rv);
		host.clear_errors();
		host.rd(ADDR_ERR, rv);
		chk_reg("err_clr", 13'h0000, rv);
		chk_bit("sef_clr", 1'b0, sef);
		// each event source in turn, bit 0 twice (supply loss, transport exit)
		for (int k = 0; k < 11; k++) begin
			ea = (k >= 7 && k <= 9) ? ADDR_ERROR_FLAGS_SECOND : ADDR_ERR;
			ev = k == 7 ? 13'h0008 : k == 8 ? 13'h0010 : k == 9 ? 13'h0040 :
				k == 10 ? 13'h0001 : 13'h0001 << k;
			pulse(k);
			repeat (4) @(posedge ref_clk);
			host.rd(ea, rv);
			chk_reg("flag", ev, rv);
			chk_bit("sef_set", 1'b1, sef);
			@(posedge ref_clk);
			mlo <= 7'h7f;
			mhi <= 7'h7f;
			repeat (2) @(posedge ref_clk);
			host.rd(ea, rv);
			chk_reg("flag_masked", ev, rv);
			chk_bit("sef_masked", 1'b0, sef);
			host.clear_errors();
			mlo <= 7'h00;
			mhi <= 7'h00;
			host.rd(ea, rv);
			chk_reg("flag_clr", 13'h0000, rv);
			chk_bit("sef_unmask", 1'b0, sef);
		end
		// clear and a new event in one cycle: the event survives
		fork
			host.clear_errors();
			pulse(4);
		join
		host.rd(ADDR_ERR, rv);
		chk_reg("set_wins", 13'h0010, rv);
		host.clear_errors();
		// ****************************************
		// control register
		// ****************************************
		b = n_lr;
		host.wr(ADDR_CTRL, 13'h1ffe);
		repeat (40) @(posedge ref_clk);
		@(negedge ref_clk);
		chk_cnt("logic_run", LC, n_lr - b);
		chk_cnt("front_run", FC, n_fr);
		chk_cnt("angle_hold", LC + FC, n_ah);
		chk_cnt("turns_clear", 1, n_tc);
		chk_bit("avg_on", 1'b1, avg);
		chk_bit("lp_on", 1'b1, lps);
		host.rd(ADDR_CTRL, rv);
		chk_reg("ctrl_rd", 13'h0006, rv);
		host.wr(ADDR_CTRL, 13'h0000);
		repeat (30) @(posedge ref_clk);
		chk_bit("avg_off", 1'b0, avg);
		chk_bit("lp_off", 1'b0, lps);
		chk_cnt("no_start", LC, n_lr - b);
		chk_cnt("no_tclr", 1, n_tc);
		// front-end test alone when only its select bit is set
		sel <= 2'b10;
		host.wr(ADDR_CTRL, 13'h0010);
		repeat (30) @(posedge ref_clk);
		@(negedge ref_clk);
		chk_cnt("front_only", 2 * FC, n_fr);
		chk_cnt("front_no_logic", LC, n_lr - b);
		chk_cnt("front_hold", LC + 2 * FC, n_ah);
		// field equal to the threshold is not below it
		@(posedge ref_clk);
		thr <= 11'h063;
		pulse(1);
		host.rd(ADDR_ERR, rv);
		chk_reg("thr_moved", 13'h0000, rv);
		host.wr(ADDR_ERR, 13'h1fff);
		host.rd(ADDR_ERR, rv);
		chk_reg("err_ro", 13'h0000, rv);
		host.rd(4'h3, rv);
		chk_reg("unmapped", 13'h0000, rv);
		// internal error then general reset, eeprom default now 0
		pulse(2);
		avd <= 1'b0;
		do_reset();
		host.rd(ADDR_ERR, rv);
		chk_reg("err_rerst", 13'h0001, rv);
		host.rd(ADDR_CTRL, rv);
		chk_reg("ctrl_rerst", 13'h0000, rv);
		stop_test();
	end
endmodule : tb
